// >>> mits_cb_store.sv
// Package of shared constants and the control-block store module
package mits_pkg;
    localparam int NUM_SRC = 15;
    localparam int CB_BYTES = 8;
    // Register byte offsets
    localparam logic [8:0] OFS_CTRL = 9'h000;
    localparam logic [8:0] OFS_MASK_LOW = 9'h004;
    localparam logic [8:0] OFS_MASK_HIGH = 9'h008;
    localparam logic [8:0] OFS_ASSIGN = 9'h00C;
    localparam logic [8:0] OFS_SOFT_EN = 9'h010;
    localparam logic [8:0] OFS_PENDING = 9'h014;
    localparam logic [8:0] OFS_IRQ_STATUS = 9'h018;
    localparam logic [8:0] OFS_IRQ_CLEAR = 9'h01C;
    localparam logic [8:0] OFS_IRQ_ENABLE = 9'h020;
    localparam logic [8:0] OFS_CB_BASE = 9'h100;
    localparam logic [8:0] OFS_CB_END = 9'h178;
    // Split of per-source server enables over the two mask registers
    localparam int MASK_LOW_BITS = 8;
    // Vector bases
    localparam logic [15:0] SOFT_VEC_LOW_BASE = 16'h2000;
    localparam logic [15:0] SOFT_VEC_HIGH_BASE = 16'h2020;
    localparam logic [15:0] SRV_VEC_BASE = 16'h2040;
    // Transfer mode codes in bits 7:5 of the mode control byte
    localparam logic [2:0] MODE_SINGLE = 3'h0;
    localparam logic [2:0] MODE_INPUT = 3'h1;
    localparam logic [2:0] MODE_OUTPUT = 3'h3;
    localparam logic [2:0] MODE_BLOCK = 3'h4;
    localparam logic [2:0] MODE_SCAN = 3'h6;
    localparam int MODE_MSB = 7;
    localparam int MODE_LSB = 5;
    // Status bit positions
    localparam int STS_RUN_DONE = 0;
    localparam int STS_MODE_ERR = 1;
    localparam int STS_BITS = 2;
    // Server write mask: count byte and both pointer words
    localparam logic [7:0] CB_WB_MASK = 8'h3D;
    // Reset values
    localparam logic [31:0] RST_WORD = 32'h0000_0000;

    // Highest-numbered requesting source
    function automatic logic [4:0] pick(input logic [NUM_SRC-1:0] req);
        logic [4:0] r;
        r = 5'h00;
        for (int i = 0; i < NUM_SRC; i++)
        begin
            if (req[i])
            begin
                r = {1'b1, 4'(i)};
            end
        end
        return r;
    endfunction

    // Software routine vector of a source
    function automatic logic [15:0] soft_vec(input logic [3:0] idx);
        return ((idx < 4'(MASK_LOW_BITS)) ? SOFT_VEC_LOW_BASE : SOFT_VEC_HIGH_BASE) + {11'h000, idx, 1'b0};
    endfunction

    // Server control-block pointer vector of a source
    function automatic logic [15:0] srv_vec(input logic [3:0] idx);
        return SRV_VEC_BASE + {11'h000, idx, 1'b0};
    endfunction
endpackage

`timescale 1ns/1ps
module mits_cb_store #(
    parameter int NUM_BLK = 15
) (
    input wire logic clk_in,
    input wire logic arst_n_in,
    input wire logic bus_we_in,
    input wire logic [4:0] bus_word_in,
    input wire logic [3:0] bus_be_in,
    input wire logic [31:0] bus_wdata_in,
    output logic [31:0] bus_rdata_out,
    input wire logic [3:0] srv_idx_in,
    input wire logic srv_we_in,
    input wire logic [7:0] srv_mask_in,
    input wire logic [63:0] srv_wdata_in,
    output logic [63:0] srv_rdata_out
);
    logic [63:0] mem [NUM_BLK];
    logic [63:0] next_mem [NUM_BLK];

    // Elaboration check of the block count
    if (NUM_BLK < 1 || NUM_BLK > 16)
    begin : g_bad_blk
        $error("NUM_BLK out of range");
    end

    // Read ports
    always_comb
    begin
        bus_rdata_out = bus_word_in[0] ? mem[bus_word_in[4:1]][63:32] : mem[bus_word_in[4:1]][31:0];
        srv_rdata_out = mem[srv_idx_in];
    end

    // Byte writes; server bytes win over a bus byte in the same cycle
    always_comb
    begin
        for (int b = 0; b < NUM_BLK; b++)
        begin
            next_mem[b] = mem[b];
            for (int k = 0; k < 8; k++)
            begin
                if (bus_we_in && bus_word_in[4:1] == 4'(b) && bus_word_in[0] == k[2] && bus_be_in[k[1:0]])
                begin
                    next_mem[b][k*8 +: 8] = bus_wdata_in[k[1:0]*8 +: 8];
                end
                if (srv_we_in && srv_idx_in == 4'(b) && srv_mask_in[k])
                begin
                    next_mem[b][k*8 +: 8] = srv_wdata_in[k*8 +: 8];
                end
            end
        end
    end

    // Storage
    always_ff @(posedge clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            for (int b = 0; b < NUM_BLK; b++)
            begin
                mem[b] <= 64'h0000_0000_0000_0000;
            end
        end
        else
        begin
            mem <= next_mem;
        end
    end
endmodule

// >>> mits_core_model.sv
// Core-side partner that takes routine vectors and transfer units
`timescale 1ns/1ps
module mits_core_model (
    input wire logic clk_in,
    input wire logic vec_req_in,
    input wire logic xfer_req_in,
    input wire logic [15:0] xfer_src_in,
    input wire logic [2:0] xfer_mode_in,
    output logic vec_ack_out,
    output logic xfer_ack_out
);
    int n_units = 0;
    logic [15:0] last_src = 16'h0000;
    logic [2:0] last_mode = 3'h0;
    // Quiet acks until the first edge
    initial
    begin
        vec_ack_out = 1'b0;
        xfer_ack_out = 1'b0;
    end
    // Random one-cycle acks; taken units logged
    always @(posedge clk_in)
    begin
        if (xfer_ack_out)
        begin
            n_units <= n_units + 1;
            last_src <= xfer_src_in;
            last_mode <= xfer_mode_in;
        end
        vec_ack_out <= vec_req_in && !vec_ack_out && 1'($urandom_range(1));
        xfer_ack_out <= xfer_req_in && !xfer_ack_out && 1'($urandom_range(1));
    end
endmodule

// >>> mits_top.sv
// Interrupt dispatcher with microcoded transaction server
//
// Functional notes
// - A pending source goes to the routine path or the server by its assignment.
// - Server service raises no vector request, leaving stack and status word alone.
// - A server cycle takes a few clocks: select, load, transfer, write back.
// - Every source has a fixed software vector and a fixed server vector.
// - Single, block, scan, output and input transfer modes are supported.
// - Each server service reads the eight-byte control block of its source.
// - Block bytes: count, mode control, pointer word, pointer word, block size.
// - Mode control bits 7:5 pick the mode; codes 010, 101 and 111 are reserved.
// - A global enable, set and cleared by two instructions, gates all server service.
// - Server service needs both the global enable and the source's own enable.
// - Per-source server enables sit in the low and high interrupt mask registers.
`timescale 1ns/1ps
module mits_top (
    input wire logic CORE_CLK_IN,
    input wire logic ARST_N_IN,
    input wire logic [8:0] AVS_ADDRESS_IN,
    input wire logic AVS_READ_IN,
    input wire logic AVS_WRITE_IN,
    input wire logic [31:0] AVS_WRITEDATA_IN,
    input wire logic [3:0] AVS_BYTEENABLE_IN,
    output logic [31:0] AVS_READDATA_OUT,
    output logic AVS_WAITREQUEST_OUT,
    input wire logic [mits_pkg::NUM_SRC-1:0] SRC_EVENT_IN,
    input wire logic SRV_ENABLE_INSTR_IN,
    input wire logic SRV_DISABLE_INSTR_IN,
    input wire logic VEC_ACK_IN,
    output logic VEC_REQ_OUT,
    output logic [15:0] VEC_ADDR_OUT,
    input wire logic XFER_ACK_IN,
    output logic XFER_REQ_OUT,
    output logic [15:0] XFER_SRC_OUT,
    output logic [15:0] XFER_DST_OUT,
    output logic [2:0] XFER_MODE_OUT,
    output logic [15:0] SRV_VEC_OUT,
    output logic SRV_BUSY_OUT,
    output logic GLOBAL_ENABLE_OUT,
    output logic IRQ_OUT
);
    localparam int N = mits_pkg::NUM_SRC;
    localparam int MASK_HI_LSB = mits_pkg::MASK_LOW_BITS;

    typedef enum logic [1:0] {S_IDLE, S_LOAD, S_XFER, S_UPDATE} mits_state_t;

    mits_state_t state, next_state;
    logic [3:0] cur, next_cur;
    logic [7:0] cnt, next_cnt;
    logic [2:0] mode, next_mode;
    logic [15:0] p1, next_p1;
    logic [15:0] p2, next_p2;
    logic [7:0] units, next_units;
    logic glob, next_glob;
    logic [7:0] mask_lo, next_mask_lo;
    logic [N-MASK_HI_LSB-1:0] mask_hi, next_mask_hi;
    logic [N-1:0] assign_srv, next_assign_srv;
    logic [N-1:0] soft_en, next_soft_en;
    logic [N-1:0] pend, next_pend;
    logic [1:0] sts, next_sts;
    logic [1:0] ien, next_ien;
    logic irq, next_irq;
    logic vec_req, next_vec_req;
    logic [3:0] vec_idx, next_vec_idx;
    logic [15:0] vec_addr, next_vec_addr;
    logic xreq, next_xreq;
    logic [15:0] xsrc, next_xsrc;
    logic [15:0] xdst, next_xdst;
    logic [15:0] svec, next_svec;
    logic busy, next_busy;
    logic wait_q, next_wait_q;
    logic [31:0] rdata, next_rdata;

    logic [N-1:0] srv_on, srv_cand, soft_cand, pend_clr, pend_set;
    logic [4:0] srv_pick, soft_pick;
    logic [1:0] sts_ev;
    logic bus_wr, bus_rd, cb_hit, srv_we;
    logic [31:0] cb_bus_rdata, wmask;
    logic [63:0] cb_rd, cb_wd;
    logic [4:0] cb_word;
    logic [8:0] cb_off;
    logic [7:0] blk;

    // Source and destination of a transfer unit per mode
    function automatic logic [31:0] route(input logic [2:0] m, input logic [15:0] a, input logic [15:0] b);
        if (m == mits_pkg::MODE_OUTPUT)
        begin
            return {a, 16'h0000};
        end
        if (m == mits_pkg::MODE_INPUT)
        begin
            return {16'h0000, a};
        end
        return {a, b};
    endfunction

    // Control-block storage
    mits_cb_store #(.NUM_BLK(N)) u_cb (
        .clk_in(CORE_CLK_IN),
        .arst_n_in(ARST_N_IN),
        .bus_we_in(bus_wr && cb_hit),
        .bus_word_in(cb_word),
        .bus_be_in(AVS_BYTEENABLE_IN),
        .bus_wdata_in(AVS_WRITEDATA_IN),
        .bus_rdata_out(cb_bus_rdata),
        .srv_idx_in(cur),
        .srv_we_in(srv_we),
        .srv_mask_in(mits_pkg::CB_WB_MASK),
        .srv_wdata_in(cb_wd),
        .srv_rdata_out(cb_rd)
    );

    // Bus decode helpers
    always_comb
    begin
        bus_rd = AVS_READ_IN && wait_q;
        bus_wr = AVS_WRITE_IN && !wait_q;
        cb_off = AVS_ADDRESS_IN - mits_pkg::OFS_CB_BASE;
        cb_word = cb_off[6:2];
        cb_hit = AVS_ADDRESS_IN >= mits_pkg::OFS_CB_BASE && AVS_ADDRESS_IN < mits_pkg::OFS_CB_END;
        wmask = {{8{AVS_BYTEENABLE_IN[3]}}, {8{AVS_BYTEENABLE_IN[2]}}, {8{AVS_BYTEENABLE_IN[1]}},
                 {8{AVS_BYTEENABLE_IN[0]}}};
        srv_on = {mask_hi, mask_lo} & assign_srv & {N{glob}};
        srv_cand = pend & srv_on;
        soft_cand = pend & ~srv_on & soft_en;
        srv_pick = mits_pkg::pick(srv_cand);
        soft_pick = mits_pkg::pick(soft_cand);
        blk = cb_rd[55:48];
        cb_wd = {16'h0000, p2, p1, 8'h00, cnt - 8'h01};
    end

    // Next-state logic
    always_comb
    begin
        next_state = state;
        next_cur = cur;
        next_cnt = cnt;
        next_mode = mode;
        next_p1 = p1;
        next_p2 = p2;
        next_units = units;
        next_glob = glob;
        next_mask_lo = mask_lo;
        next_mask_hi = mask_hi;
        next_assign_srv = assign_srv;
        next_soft_en = soft_en;
        next_sts = sts;
        next_ien = ien;
        next_vec_req = vec_req;
        next_vec_idx = vec_idx;
        next_vec_addr = vec_addr;
        next_xreq = xreq;
        next_xsrc = xsrc;
        next_xdst = xdst;
        next_svec = svec;
        next_busy = busy;
        next_rdata = rdata;
        pend_clr = '0;
        pend_set = '0;
        sts_ev = 2'h0;
        srv_we = 1'b0;
        // One wait cycle per access
        next_wait_q = !((AVS_READ_IN || AVS_WRITE_IN) && wait_q);
        // Register reads captured while waitrequest is high
        if (bus_rd)
        begin
            if (AVS_ADDRESS_IN == mits_pkg::OFS_CTRL)
            begin
                next_rdata = {31'h0, glob};
            end
            else if (AVS_ADDRESS_IN == mits_pkg::OFS_MASK_LOW)
            begin
                next_rdata = {24'h0, mask_lo};
            end
            else if (AVS_ADDRESS_IN == mits_pkg::OFS_MASK_HIGH)
            begin
                next_rdata = {25'h0, mask_hi};
            end
            else if (AVS_ADDRESS_IN == mits_pkg::OFS_ASSIGN)
            begin
                next_rdata = {17'h0, assign_srv};
            end
            else if (AVS_ADDRESS_IN == mits_pkg::OFS_SOFT_EN)
            begin
                next_rdata = {17'h0, soft_en};
            end
            else if (AVS_ADDRESS_IN == mits_pkg::OFS_PENDING)
            begin
                next_rdata = {17'h0, pend};
            end
            else if (AVS_ADDRESS_IN == mits_pkg::OFS_IRQ_STATUS)
            begin
                next_rdata = {30'h0, sts};
            end
            else if (AVS_ADDRESS_IN == mits_pkg::OFS_IRQ_ENABLE)
            begin
                next_rdata = {30'h0, ien};
            end
            else if (cb_hit)
            begin
                next_rdata = cb_bus_rdata;
            end
            else
            begin
                next_rdata = mits_pkg::RST_WORD;
            end
        end
        // Register writes on the accepting edge
        if (bus_wr)
        begin
            if (AVS_ADDRESS_IN == mits_pkg::OFS_CTRL && AVS_BYTEENABLE_IN[0])
            begin
                next_glob = AVS_WRITEDATA_IN[0];
            end
            else if (AVS_ADDRESS_IN == mits_pkg::OFS_MASK_LOW && AVS_BYTEENABLE_IN[0])
            begin
                next_mask_lo = AVS_WRITEDATA_IN[7:0];
            end
            else if (AVS_ADDRESS_IN == mits_pkg::OFS_MASK_HIGH && AVS_BYTEENABLE_IN[0])
            begin
                next_mask_hi = AVS_WRITEDATA_IN[N-MASK_HI_LSB-1:0];
            end
            else if (AVS_ADDRESS_IN == mits_pkg::OFS_ASSIGN)
            begin
                next_assign_srv = (assign_srv & ~wmask[N-1:0]) | (AVS_WRITEDATA_IN[N-1:0] & wmask[N-1:0]);
            end
            else if (AVS_ADDRESS_IN == mits_pkg::OFS_SOFT_EN)
            begin
                next_soft_en = (soft_en & ~wmask[N-1:0]) | (AVS_WRITEDATA_IN[N-1:0] & wmask[N-1:0]);
            end
            else if (AVS_ADDRESS_IN == mits_pkg::OFS_IRQ_CLEAR && AVS_BYTEENABLE_IN[0])
            begin
                next_sts = sts & ~AVS_WRITEDATA_IN[1:0];
            end
            else if (AVS_ADDRESS_IN == mits_pkg::OFS_IRQ_ENABLE && AVS_BYTEENABLE_IN[0])
            begin
                next_ien = AVS_WRITEDATA_IN[1:0];
            end
        end
        // Instructions override a same-cycle bus write
        if (SRV_ENABLE_INSTR_IN)
        begin
            next_glob = 1'b1;
        end
        else if (SRV_DISABLE_INSTR_IN)
        begin
            next_glob = 1'b0;
        end
        // Routine path
        if (vec_req && VEC_ACK_IN)
        begin
            next_vec_req = 1'b0;
            pend_clr[vec_idx] = 1'b1;
        end
        else if (!vec_req && soft_pick[4])
        begin
            next_vec_req = 1'b1;
            next_vec_idx = soft_pick[3:0];
            next_vec_addr = mits_pkg::soft_vec(soft_pick[3:0]);
        end
        // Transaction server; never raises a vector request
        case (state)
            S_IDLE:
            begin
                if (srv_pick[4])
                begin
                    next_cur = srv_pick[3:0];
                    pend_clr[srv_pick[3:0]] = 1'b1;
                    next_svec = mits_pkg::srv_vec(srv_pick[3:0]);
                    next_busy = 1'b1;
                    next_state = S_LOAD;
                end
            end
            S_LOAD:
            begin
                next_cnt = cb_rd[7:0];
                next_mode = cb_rd[8+mits_pkg::MODE_MSB:8+mits_pkg::MODE_LSB];
                next_p1 = cb_rd[31:16];
                next_p2 = cb_rd[47:32];
                next_units = (next_mode == mits_pkg::MODE_SINGLE || next_mode == mits_pkg::MODE_SCAN || blk == 8'h00)
                             ? 8'h01 : blk;
                {next_xsrc, next_xdst} = route(next_mode, next_p1, next_p2);
                if (!(next_mode inside {mits_pkg::MODE_SINGLE, mits_pkg::MODE_INPUT, mits_pkg::MODE_OUTPUT,
                                        mits_pkg::MODE_BLOCK, mits_pkg::MODE_SCAN}))
                begin
                    // Reserved code: leave the server, fall back to the routine
                    next_assign_srv[cur] = 1'b0;
                    pend_set[cur] = 1'b1;
                    sts_ev[mits_pkg::STS_MODE_ERR] = 1'b1;
                    next_busy = 1'b0;
                    next_state = S_IDLE;
                end
                else if (next_cnt == 8'h00)
                begin
                    next_assign_srv[cur] = 1'b0;
                    pend_set[cur] = 1'b1;
                    sts_ev[mits_pkg::STS_RUN_DONE] = 1'b1;
                    next_busy = 1'b0;
                    next_state = S_IDLE;
                end
                else
                begin
                    next_xreq = 1'b1;
                    next_state = S_XFER;
                end
            end
            S_XFER:
            begin
                if (XFER_ACK_IN)
                begin
                    // Pointer stepping per mode
                    if (mode == mits_pkg::MODE_BLOCK)
                    begin
                        next_p1 = p1 + 16'h0001;
                        next_p2 = p2 + 16'h0001;
                    end
                    else if (mode == mits_pkg::MODE_OUTPUT || mode == mits_pkg::MODE_INPUT)
                    begin
                        next_p1 = p1 + 16'h0001;
                    end
                    next_units = units - 8'h01;
                    {next_xsrc, next_xdst} = route(mode, next_p1, next_p2);
                    if (units == 8'h01)
                    begin
                        next_xreq = 1'b0;
                        next_state = S_UPDATE;
                    end
                end
            end
            default:
            begin
                srv_we = 1'b1;
                next_cnt = cnt - 8'h01;
                if (cnt == 8'h01)
                begin
                    next_assign_srv[cur] = 1'b0;
                    pend_set[cur] = 1'b1;
                    sts_ev[mits_pkg::STS_RUN_DONE] = 1'b1;
                end
                next_busy = 1'b0;
                next_state = S_IDLE;
            end
        endcase
        // New events and hardware sets win over clears
        next_pend = (pend & ~pend_clr) | pend_set | SRC_EVENT_IN;
        next_sts = next_sts | sts_ev;
        next_irq = |(next_sts & next_ien);
    end

    // State registers
    always_ff @(posedge CORE_CLK_IN or negedge ARST_N_IN)
    begin
        if (!ARST_N_IN)
        begin
            state <= S_IDLE;
            cur <= '0;
            cnt <= '0;
            mode <= '0;
            p1 <= '0;
            p2 <= '0;
            units <= '0;
            glob <= '0;
            mask_lo <= '0;
            mask_hi <= '0;
            assign_srv <= '0;
            soft_en <= '0;
            pend <= '0;
            sts <= '0;
            ien <= '0;
            irq <= '0;
            vec_req <= '0;
            vec_idx <= '0;
            vec_addr <= '0;
            xreq <= '0;
            xsrc <= '0;
            xdst <= '0;
            svec <= '0;
            busy <= '0;
            wait_q <= 1'b1;
            rdata <= mits_pkg::RST_WORD;
        end
        else
        begin
            state <= next_state;
            cur <= next_cur;
            cnt <= next_cnt;
            mode <= next_mode;
            p1 <= next_p1;
            p2 <= next_p2;
            units <= next_units;
            glob <= next_glob;
            mask_lo <= next_mask_lo;
            mask_hi <= next_mask_hi;
            assign_srv <= next_assign_srv;
            soft_en <= next_soft_en;
            pend <= next_pend;
            sts <= next_sts;
            ien <= next_ien;
            irq <= next_irq;
            vec_req <= next_vec_req;
            vec_idx <= next_vec_idx;
            vec_addr <= next_vec_addr;
            xreq <= next_xreq;
            xsrc <= next_xsrc;
            xdst <= next_xdst;
            svec <= next_svec;
            busy <= next_busy;
            wait_q <= next_wait_q;
            rdata <= next_rdata;
        end
    end

    // Outputs straight from flops
    assign AVS_READDATA_OUT = rdata;
    assign AVS_WAITREQUEST_OUT = wait_q;
    assign VEC_REQ_OUT = vec_req;
    assign VEC_ADDR_OUT = vec_addr;
    assign XFER_REQ_OUT = xreq;
    assign XFER_SRC_OUT = xsrc;
    assign XFER_DST_OUT = xdst;
    assign XFER_MODE_OUT = mode;
    assign SRV_VEC_OUT = svec;
    assign SRV_BUSY_OUT = busy;
    assign GLOBAL_ENABLE_OUT = glob;
    assign IRQ_OUT = irq;
endmodule

// >>> mits_top_sva.sv
// Checker of bus, vector and server handshakes
`timescale 1ns/1ps
module mits_top_sva (
    input wire logic CORE_CLK_IN,
    input wire logic ARST_N_IN,
    input wire logic AVS_READ_IN,
    input wire logic AVS_WRITE_IN,
    input wire logic AVS_WAITREQUEST_OUT,
    input wire logic SRV_ENABLE_INSTR_IN,
    input wire logic SRV_DISABLE_INSTR_IN,
    input wire logic VEC_ACK_IN,
    input wire logic VEC_REQ_OUT,
    input wire logic [15:0] VEC_ADDR_OUT,
    input wire logic XFER_ACK_IN,
    input wire logic XFER_REQ_OUT,
    input wire logic [15:0] XFER_SRC_OUT,
    input wire logic [2:0] XFER_MODE_OUT,
    input wire logic [15:0] SRV_VEC_OUT,
    input wire logic SRV_BUSY_OUT,
    input wire logic GLOBAL_ENABLE_OUT
);
    default clocking dc @(posedge CORE_CLK_IN);
    endclocking
    default disable iff (!ARST_N_IN);
    // Bus answer and held transfer unit
    sequence s_answer;
        !AVS_WAITREQUEST_OUT ##1 AVS_WAITREQUEST_OUT;
    endsequence
    sequence s_unit_held;
        XFER_REQ_OUT && $stable(XFER_SRC_OUT) && $stable(XFER_MODE_OUT);
    endsequence
    AST_BUS_ANSWER: assert property ((AVS_READ_IN || AVS_WRITE_IN) && AVS_WAITREQUEST_OUT |=> s_answer)
        else $error("bus answer late");
    AST_VEC_HOLD: assert property (VEC_REQ_OUT && !VEC_ACK_IN |=> VEC_REQ_OUT && $stable(VEC_ADDR_OUT))
        else $error("vector dropped");
    AST_VEC_TABLE: assert property (VEC_REQ_OUT |-> !VEC_ADDR_OUT[0] &&
        VEC_ADDR_OUT inside {[16'h2000:16'h200E], [16'h2030:16'h203C]}) else $error("bad vector");
    AST_SRV_TABLE: assert property (SRV_BUSY_OUT |-> !SRV_VEC_OUT[0] && SRV_VEC_OUT inside {[16'h2040:16'h205C]})
        else $error("bad server vector");
    AST_UNIT_HOLD: assert property (XFER_REQ_OUT && !XFER_ACK_IN |=> s_unit_held)
        else $error("unit dropped");
    AST_MODE_LEGAL: assert property (XFER_REQ_OUT |-> SRV_BUSY_OUT && XFER_MODE_OUT inside {3'h0, 3'h1, 3'h3, 3'h4, 3'h6})
        else $error("bad mode");
    AST_GLOBAL_SET: assert property (SRV_ENABLE_INSTR_IN |=> GLOBAL_ENABLE_OUT)
        else $error("enable lost");
    AST_GLOBAL_CLR: assert property (SRV_DISABLE_INSTR_IN && !SRV_ENABLE_INSTR_IN |=> !GLOBAL_ENABLE_OUT)
        else $error("disable lost");
    AST_BUSY_GATED: assert property ($rose(SRV_BUSY_OUT) |-> $past(GLOBAL_ENABLE_OUT))
        else $error("server ran disabled");
endmodule

bind mits_top mits_top_sva mits_top_sva_inst (.*);

// >>> mits_top_tb.sv
// Testbench of the interrupt dispatcher and transaction server
`timescale 1ns/1ps
module mits_top_tb;
    logic clk = 1'b0, rst_n = 1'b0, rd = 1'b0, wr = 1'b0, en_i = 1'b0, dis_i = 1'b0;
    logic [8:0] adr = 9'h000;
    logic [31:0] wd = 32'h0;
    logic [3:0] be = 4'hF;
    logic [14:0] ev = 15'h0;
    logic waitr, vack, vreq, xack, xreq, busy, glob, irq;
    logic [31:0] rdata, q;
    logic [15:0] vaddr, xsrc, svec, p;
    logic [2:0] xmode;
    int n_mismatch = 0;
    int num_checks = 0;
    int s, u0;
    // Case table: mode code, units, pointer step, source pointer used
    logic [2:0] code [6] = '{3'h0, 3'h1, 3'h3, 3'h4, 3'h6, 3'h2};
    int units [6] = '{1, 2, 2, 2, 1, 0};
    int step [6] = '{0, 0, 1, 1, 0, 0};
    int use_src [6] = '{1, 0, 1, 1, 1, 0};
    int vsrc [$] = '{0, 7, 8, 14};
    logic [8:0] regs [$] = '{9'h000, 9'h004, 9'h008, 9'h00C, 9'h014, 9'h018, 9'h01C, 9'h020, 9'h040};

    mits_top mits_top_inst (.CORE_CLK_IN(clk), .ARST_N_IN(rst_n), .AVS_ADDRESS_IN(adr), .AVS_READ_IN(rd),
        .AVS_WRITE_IN(wr), .AVS_WRITEDATA_IN(wd), .AVS_BYTEENABLE_IN(be), .AVS_READDATA_OUT(rdata),
        .AVS_WAITREQUEST_OUT(waitr), .SRC_EVENT_IN(ev), .SRV_ENABLE_INSTR_IN(en_i), .SRV_DISABLE_INSTR_IN(dis_i),
        .VEC_ACK_IN(vack), .VEC_REQ_OUT(vreq), .VEC_ADDR_OUT(vaddr), .XFER_ACK_IN(xack), .XFER_REQ_OUT(xreq),
        .XFER_SRC_OUT(xsrc), .XFER_DST_OUT(), .XFER_MODE_OUT(xmode), .SRV_VEC_OUT(svec), .SRV_BUSY_OUT(busy),
        .GLOBAL_ENABLE_OUT(glob), .IRQ_OUT(irq));
    mits_core_model mits_core_model_inst (.clk_in(clk), .vec_req_in(vreq), .xfer_req_in(xreq),
        .xfer_src_in(xsrc), .xfer_mode_in(xmode), .vec_ack_out(vack), .xfer_ack_out(xack));

    // Clock at 125 MHz
    initial
    begin
        forever #4 clk = ~clk;
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic print_verdict;
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // Bounded wait for a level
    task automatic wait_for(ref logic sig, input logic lvl);
        int k;
        k = 0;
        while (sig !== lvl)
        begin
            @(posedge clk);
            k++;
            if (k > 300)
            begin
                n_mismatch++;
                print_verdict();
            end
        end
    endtask

    // One bus access
    task automatic bus(input logic w, input logic [8:0] a, input logic [31:0] d, input logic [3:0] b);
        wr <= w;
        rd <= !w;
        adr <= a;
        wd <= d;
        be <= b;
        @(posedge clk);
        wait_for(waitr, 1'b0);
        q = rdata;
        wr <= 1'b0;
        rd <= 1'b0;
        @(posedge clk);
    endtask

    task automatic pulse_src(input int i);
        ev <= 15'(1 << i);
        @(posedge clk);
        ev <= 15'h0;
    endtask

    // Main sequence
    initial
    begin
        void'($urandom(32'hFBBFBF65));
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        foreach (regs[i])
        begin
            bus(1'b0, regs[i], 0, 4'hF);
            chk(q, 0);
        end
        p = 16'($urandom());
        bus(1'b1, 9'h004, {16'h0, p}, 4'h1);
        bus(1'b0, 9'h004, 0, 4'hF);
        chk(q, p[7:0]);
        $display("test registers done");
        bus(1'b1, 9'h010, 32'h7FFF, 4'hF);
        foreach (vsrc[i])
        begin
            pulse_src(vsrc[i]);
            wait_for(vreq, 1'b1);
            chk(vaddr, (vsrc[i] < 8 ? 32'h2000 : 32'h2020) + 2 * vsrc[i]);
            wait_for(vreq, 1'b0);
        end
        bus(1'b1, 9'h010, 0, 4'hF);
        $display("test vectors done");
        en_i <= 1'b1;
        @(posedge clk);
        en_i <= 1'b0;
        @(posedge clk);
        chk(glob, 1);
        bus(1'b1, 9'h004, 32'hFF, 4'hF);
        bus(1'b1, 9'h008, 32'h7F, 4'hF);
        bus(1'b1, 9'h020, 32'h1, 4'hF);
        for (int m = 0; m < 6; m++)
        begin
            s = m + 2;
            p = 16'($urandom_range(16'hFFF0));
            bus(1'b1, 9'(9'h100 + 8 * s), {p, code[m], 5'h00, 8'h01}, 4'hF);
            bus(1'b1, 9'(9'h104 + 8 * s), {16'h0002, 16'($urandom())}, 4'hF);
            bus(1'b1, 9'h00C, 32'(1 << s), 4'hF);
            u0 = mits_core_model_inst.n_units;
            pulse_src(s);
            wait_for(busy, 1'b1);
            chk(svec, 32'h2040 + 2 * s);
            wait_for(busy, 1'b0);
            chk(mits_core_model_inst.n_units - u0, units[m]);
            if (units[m] > 0)
            begin
                chk(mits_core_model_inst.last_mode, code[m]);
                chk(mits_core_model_inst.last_src, use_src[m] * (p + step[m]));
            end
            bus(1'b0, 9'(9'h100 + 8 * s), 0, 4'hF);
            chk(q[7:0], m == 5);
            bus(1'b0, 9'h00C, 0, 4'hF);
            chk(q, 0);
            bus(1'b0, 9'h018, 0, 4'hF);
            chk(q, m == 5 ? 2 : 1);
            chk(irq, m != 5);
            bus(1'b1, 9'h01C, 3, 4'hF);
            @(posedge clk);
            chk(irq, 0);
        end
        $display("test modes done");
        dis_i <= 1'b1;
        @(posedge clk);
        dis_i <= 1'b0;
        @(posedge clk);
        chk(glob, 0);
        bus(1'b1, 9'h148, 32'h1, 4'hF);
        bus(1'b1, 9'h00C, 32'h200, 4'hF);
        pulse_src(9);
        repeat (10) @(posedge clk);
        chk(busy, 0);
        bus(1'b0, 9'h014, 0, 4'hF);
        chk(q, 32'h02FC);
        $display("test global gate done");
        print_verdict();
    end
endmodule
